// File: hdl/watchdog_timer.sv
// Watchdog timer with period select, shared prescaler and AHB-Lite registers
//
// Chosen here: the register offsets and register access over AHB-Lite.
module watchdog_timer #(
  parameter int STAGE_ONE_W = watchdog_pkg::STAGE_ONE_W,
  parameter int STAGE_TWO_W = watchdog_pkg::STAGE_TWO_W
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic low_freq_internal_osc_in,
  input wire logic config_watchdog_enable_in,
  input wire logic crystal_osc_mode_in,
  input wire logic osc_startup_timer_busy_in,
  input wire logic clear_watchdog_instr_in,
  input wire logic osc_fail_in,
  input wire logic sleep_enter_in,
  input wire logic wake_event_in,
  input wire logic lowfreq_sysclk_ready_in,
  output logic watchdog_reset_out,
  output logic watchdog_wake_out,
  output logic sleeping_out,
  output logic lowfreq_stable_flag_out,
  output logic timeout_flag_out
);

  localparam int SEL_ONE_W = $clog2(STAGE_ONE_W + 1);
  localparam int SEL_TWO_W = $clog2(STAGE_TWO_W + 1);

  if (STAGE_ONE_W < int'(watchdog_pkg::PERIOD_BASE_BITS) + int'(watchdog_pkg::PERIOD_MAX_CODE)
      || STAGE_TWO_W < (1 << watchdog_pkg::PRESCALE_RATIO_W) - 1) begin : g_bad_size
    $error("watchdog_timer: prescaler stages too short for the period and ratio fields");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and oscillator synchroniser

  logic rst_meta_reg;
  logic rst_n;
  logic osc_meta_reg;
  logic osc_sync_reg;
  logic osc_prev_reg;
  logic lf_tick;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= low_freq_internal_osc_in;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // The chain sees the oscillator, never the system clock source
  assign lf_tick = osc_sync_reg && !osc_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [watchdog_pkg::PERIOD_W-1:0] period_reg;
  logic [watchdog_pkg::PERIOD_W-1:0] period_next;
  logic soft_en_reg;
  logic soft_en_next;
  logic [7:0] option_reg;
  logic [7:0] option_next;
  logic timeout_flag_reg;
  logic timeout_flag_next;
  logic wake_flag_reg;
  logic wake_flag_next;
  logic dphase_reg;
  logic dphase_next;
  logic dphase_write_reg;
  logic dphase_write_next;
  logic [watchdog_pkg::DECODE_W-1:0] dphase_addr_reg;
  logic [watchdog_pkg::DECODE_W-1:0] dphase_addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog state

  watchdog_pkg::power_state_type state_reg;
  watchdog_pkg::power_state_type state_next;
  logic hold_reg;
  logic hold_next;
  logic ost_prev_reg;
  logic reset_pulse_reg;
  logic reset_pulse_next;
  logic wake_pulse_reg;
  logic wake_pulse_next;
  logic lts_reg;

  logic enabled;
  logic exit_sleep;
  logic ost_done;
  logic chain_clear;
  logic carry_one;
  logic carry_two;
  logic stage_two_clear;
  logic timeout_evt;
  logic assign_to_wdt;
  logic [watchdog_pkg::PERIOD_W-1:0] period_used;
  logic [SEL_ONE_W-1:0] tap_one;
  logic [SEL_TWO_W-1:0] tap_two;

  function automatic logic [31:0] read_word(
    input logic [watchdog_pkg::DECODE_W-1:0] addr,
    input logic [watchdog_pkg::PERIOD_W-1:0] period,
    input logic soft_en,
    input logic [7:0] option,
    input logic [watchdog_pkg::STATUS_W-1:0] status
  );
    logic [31:0] word;
    word = '0;
    case (addr)
      watchdog_pkg::CONTROL_OFFSET: begin
        // Upper control bits are unimplemented
        word[watchdog_pkg::CONTROL_USED_W-1:0] = {period, soft_en};
      end
      watchdog_pkg::OPTION_OFFSET: begin
        word[7:0] = option;
      end
      watchdog_pkg::STATUS_OFFSET: begin
        word[watchdog_pkg::STATUS_W-1:0] = status;
      end
      default: begin
        word = '0;
      end
    endcase
    return word;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Enable, clear and chain control

  always_comb begin
    enabled = config_watchdog_enable_in || soft_en_reg;
    exit_sleep = (state_reg == watchdog_pkg::SLEEP_STATE) && (wake_event_in || wake_pulse_next);
    ost_done = ost_prev_reg && !osc_startup_timer_busy_in;
    assign_to_wdt = option_reg[watchdog_pkg::PRESCALER_ASSIGN_BIT];
    // Reserved codes act as the longest period rather than wrapping short
    period_used = (period_reg > watchdog_pkg::PERIOD_MAX_CODE) ? watchdog_pkg::PERIOD_MAX_CODE : period_reg;
    tap_one = SEL_ONE_W'(watchdog_pkg::PERIOD_BASE_BITS) + SEL_ONE_W'(period_used);
    tap_two = SEL_TWO_W'(option_reg[watchdog_pkg::PRESCALE_RATIO_LSB +: watchdog_pkg::PRESCALE_RATIO_W]);
    chain_clear = !enabled
      || clear_watchdog_instr_in
      || osc_fail_in
      || osc_startup_timer_busy_in
      || hold_reg
      || sleep_enter_in
      || (state_reg == watchdog_pkg::SLEEP_STATE && wake_event_in)
      || reset_pulse_reg
      || wake_pulse_reg;
    // While the timer owns the shared stage, the watchdog bypasses it
    stage_two_clear = chain_clear || !assign_to_wdt;
    timeout_evt = assign_to_wdt ? carry_two : carry_one;
  end

  watchdog_prescaler #(
    .WIDTH(STAGE_ONE_W),
    .SEL_W(SEL_ONE_W)
  ) stage_one (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .clear_in(chain_clear),
    .tick_in(lf_tick),
    .tap_bits_in(tap_one),
    .carry_out(carry_one)
  );

  watchdog_prescaler #(
    .WIDTH(STAGE_TWO_W),
    .SEL_W(SEL_TWO_W)
  ) stage_two (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .clear_in(stage_two_clear),
    .tick_in(carry_one),
    .tap_bits_in(tap_two),
    .carry_out(carry_two)
  );

  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    reset_pulse_next = 1'b0;
    wake_pulse_next = 1'b0;
    case (state_reg)
      watchdog_pkg::RUN_STATE: begin
        reset_pulse_next = timeout_evt;
        if (sleep_enter_in && !timeout_evt) begin
          state_next = watchdog_pkg::SLEEP_STATE;
        end
      end
      watchdog_pkg::SLEEP_STATE: begin
        wake_pulse_next = timeout_evt;
        if (wake_event_in || timeout_evt) begin
          state_next = watchdog_pkg::RUN_STATE;
        end
      end
      default: begin
        state_next = watchdog_pkg::RUN_STATE;
      end
    endcase
    if (exit_sleep && crystal_osc_mode_in) begin
      hold_next = 1'b1;
    end else if (ost_done) begin
      hold_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= watchdog_pkg::RUN_STATE;
      hold_reg <= 1'b0;
      ost_prev_reg <= 1'b0;
      reset_pulse_reg <= 1'b0;
      wake_pulse_reg <= 1'b0;
      lts_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      ost_prev_reg <= osc_startup_timer_busy_in;
      reset_pulse_reg <= reset_pulse_next;
      wake_pulse_reg <= wake_pulse_next;
      lts_reg <= lowfreq_sysclk_ready_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave and software registers

  always_comb begin
    logic take;
    logic wr;
    logic [7:0] wbyte;
    take = 1'b0;
    wr = 1'b0;
    wbyte = hwdata_in[7:0];
    take = hsel_in && htrans_in[watchdog_pkg::HTRANS_ACTIVE_BIT] && hready_in;
    wr = dphase_reg && dphase_write_reg;
    dphase_next = take;
    dphase_write_next = take && hwrite_in;
    dphase_addr_next = take ? haddr_in[watchdog_pkg::DECODE_W-1:0] : dphase_addr_reg;
    period_next = period_reg;
    soft_en_next = soft_en_reg;
    option_next = option_reg;
    timeout_flag_next = timeout_flag_reg;
    wake_flag_next = wake_flag_reg;
    if (wr && dphase_addr_reg == watchdog_pkg::CONTROL_OFFSET) begin
      period_next = wbyte[watchdog_pkg::PERIOD_LSB +: watchdog_pkg::PERIOD_W];
      soft_en_next = wbyte[watchdog_pkg::SOFT_EN_BIT];
    end
    if (wr && dphase_addr_reg == watchdog_pkg::OPTION_OFFSET) begin
      option_next = wbyte;
    end
    if (wr && dphase_addr_reg == watchdog_pkg::STATUS_OFFSET) begin
      timeout_flag_next = timeout_flag_reg && !wbyte[watchdog_pkg::TIMEOUT_BIT];
      wake_flag_next = wake_flag_reg && !wbyte[watchdog_pkg::WAKE_BIT];
    end
    // The watchdog reset is a device reset, so control and option reload
    if (reset_pulse_reg) begin
      period_next = watchdog_pkg::CONTROL_RESET[watchdog_pkg::PERIOD_LSB +: watchdog_pkg::PERIOD_W];
      soft_en_next = watchdog_pkg::CONTROL_RESET[watchdog_pkg::SOFT_EN_BIT];
      option_next = watchdog_pkg::OPTION_RESET;
    end
    // Hardware sets win over a software clear in the same cycle
    if (reset_pulse_reg) begin
      timeout_flag_next = 1'b1;
    end
    if (wake_pulse_reg) begin
      wake_flag_next = 1'b1;
    end
    // Read data follows any write landing this cycle
    hrdata_next = take ? read_word(haddr_in[watchdog_pkg::DECODE_W-1:0], period_next, soft_en_next, option_next,
                                   {hold_next, state_next == watchdog_pkg::SLEEP_STATE, enabled, wake_flag_next,
                                    timeout_flag_next}) : hrdata_reg;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      period_reg <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::PERIOD_LSB +: watchdog_pkg::PERIOD_W];
      soft_en_reg <= watchdog_pkg::CONTROL_RESET[watchdog_pkg::SOFT_EN_BIT];
      option_reg <= watchdog_pkg::OPTION_RESET;
      timeout_flag_reg <= watchdog_pkg::STATUS_RESET[watchdog_pkg::TIMEOUT_BIT];
      wake_flag_reg <= watchdog_pkg::STATUS_RESET[watchdog_pkg::WAKE_BIT];
      dphase_reg <= 1'b0;
      dphase_write_reg <= 1'b0;
      dphase_addr_reg <= '0;
      hrdata_reg <= '0;
    end else begin
      period_reg <= period_next;
      soft_en_reg <= soft_en_next;
      option_reg <= option_next;
      timeout_flag_reg <= timeout_flag_next;
      wake_flag_reg <= wake_flag_next;
      dphase_reg <= dphase_next;
      dphase_write_reg <= dphase_write_next;
      dphase_addr_reg <= dphase_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states; narrower sizes act on the low byte
  assign hreadyout_out = 1'b1;
  assign hresp_out = watchdog_pkg::HRESP_OKAY;
  assign hrdata_out = hrdata_reg;
  // Internal reset request only; this block has no path to the master clear pin
  assign watchdog_reset_out = reset_pulse_reg;
  assign watchdog_wake_out = wake_pulse_reg;
  assign sleeping_out = (state_reg == watchdog_pkg::SLEEP_STATE);
  assign lowfreq_stable_flag_out = lts_reg;
  assign timeout_flag_out = timeout_flag_reg;

endmodule

// File: hdl/watchdog_pkg.sv
// Shared constants and types for the watchdog timer and its prescaler stages
package watchdog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses inside the decoded window
  localparam int DECODE_W = 8;
  localparam logic [DECODE_W-1:0] CONTROL_OFFSET = 8'h00;
  localparam logic [DECODE_W-1:0] OPTION_OFFSET = 8'h04;
  localparam logic [DECODE_W-1:0] STATUS_OFFSET = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog control fields
  localparam int SOFT_EN_BIT = 0;
  localparam int PERIOD_LSB = 1;
  localparam int PERIOD_W = 4;
  localparam int CONTROL_USED_W = 5;
  localparam logic [3:0] PERIOD_MAX_CODE = 4'hb;
  // Code 0 selects 1:32, so five low bits of the first stage must be ones
  localparam logic [4:0] PERIOD_BASE_BITS = 5'h05;

  ////////////////////////////////////////////////////////////////////////////
  // Option control fields
  localparam int PRESCALE_RATIO_LSB = 0;
  localparam int PRESCALE_RATIO_W = 3;
  localparam int PRESCALER_ASSIGN_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Status fields
  localparam int TIMEOUT_BIT = 0;
  localparam int WAKE_BIT = 1;
  localparam int RUNNING_BIT = 2;
  localparam int ASLEEP_BIT = 3;
  localparam int HOLD_BIT = 4;
  localparam int STATUS_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler chain sizes
  localparam int STAGE_ONE_W = 16;
  localparam int STAGE_TWO_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Bus encodings
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {
    RUN_STATE,
    SLEEP_STATE
  } power_state_type;

endpackage

// File: hdl/watchdog_prescaler.sv
// One synchronous prescaler stage with a selectable carry tap
module watchdog_prescaler #(
  parameter int WIDTH = 16,
  parameter int SEL_W = 5
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic [SEL_W-1:0] tap_bits_in,
  output logic carry_out
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] mask;

  if (WIDTH < 1 || (1 << SEL_W) <= WIDTH) begin : g_bad_size
    $error("watchdog_prescaler: tap select cannot reach every width");
  end

  // Mask of the low bits that must all be ones for a carry
  function automatic logic [WIDTH-1:0] low_mask(input logic [SEL_W-1:0] bits);
    logic [WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (i < int'(bits)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  always_comb begin
    mask = low_mask(tap_bits_in);
    carry_out = tick_in && !clear_in && ((count_reg & mask) == mask);
    count_next = count_reg;
    if (clear_in) begin
      count_next = '0;
    end else if (tick_in) begin
      count_next = count_reg + WIDTH'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// File: verification/watchdog_timer_asserts.sv
// Port-level assertion checker for the watchdog timer
module watchdog_timer_asserts (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic osc_startup_timer_busy_in,
  input wire logic clear_watchdog_instr_in,
  input wire logic osc_fail_in,
  input wire logic sleep_enter_in,
  input wire logic lowfreq_sysclk_ready_in,
  input wire logic watchdog_reset_out,
  input wire logic watchdog_wake_out,
  input wire logic sleeping_out,
  input wire logic lowfreq_stable_flag_out,
  input wire logic timeout_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  ////////////////////////////////////////////////////////////////////////////
  // Three cycles give margin over the one-cycle pulse register
  sequence held_clear_seq;
    (clear_watchdog_instr_in || osc_fail_in) [*3];
  endsequence
  sequence startup_hold_seq;
    osc_startup_timer_busy_in [*3];
  endsequence
  sequence bus_quiet_seq;
    !hsel_in [*3] ##0 timeout_flag_out;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  chk_reset_one_cycle:
  assert property (watchdog_reset_out |=> !watchdog_reset_out) else $error("reset pulse too long");
  chk_reset_awake_only:
  assert property (watchdog_reset_out |-> !$past(sleeping_out)) else $error("reset pulse while asleep");
  chk_wake_from_sleep:
  assert property (watchdog_wake_out |-> $past(sleeping_out) && !sleeping_out) else $error("bad wake pulse");
  chk_flag_on_timeout:
  assert property (watchdog_reset_out |-> ##[0:1] timeout_flag_out) else $error("time-out flag not set");
  chk_flag_sticky:
  assert property (bus_quiet_seq |=> timeout_flag_out) else $error("time-out flag lost");
  chk_clear_blocks_out:
  assert property (held_clear_seq |-> !watchdog_reset_out && !watchdog_wake_out) else $error("time-out while cleared");
  chk_startup_blocks:
  assert property (startup_hold_seq |-> !watchdog_reset_out && !watchdog_wake_out) else $error("time-out in start-up");
  chk_stable_flag_copy:
  assert property ($past(resetn_in, 4) |-> lowfreq_stable_flag_out == $past(lowfreq_sysclk_ready_in))
    else $error("stable flag not a copy of its input");
  chk_sleep_entry:
  assert property (sleep_enter_in && !sleeping_out |=> sleeping_out || watchdog_reset_out)
    else $error("sleep not entered");
endmodule

bind watchdog_timer watchdog_timer_asserts watchdog_timer_asserts_inst (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .hsel_in(hsel_in),
  .osc_startup_timer_busy_in(osc_startup_timer_busy_in),
  .clear_watchdog_instr_in(clear_watchdog_instr_in),
  .osc_fail_in(osc_fail_in),
  .sleep_enter_in(sleep_enter_in),
  .lowfreq_sysclk_ready_in(lowfreq_sysclk_ready_in),
  .watchdog_reset_out(watchdog_reset_out),
  .watchdog_wake_out(watchdog_wake_out),
  .sleeping_out(sleeping_out),
  .lowfreq_stable_flag_out(lowfreq_stable_flag_out),
  .timeout_flag_out(timeout_flag_out)
);

// File: verification/testbench.sv
// Self-checking testbench for the watchdog timer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, resetn_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, osc = 1'b0, cfg_en = 1'b0;
  logic xtal = 1'b0, busy = 1'b0, clr = 1'b0, fail = 1'b0, slp = 1'b0, wake_ev = 1'b0, ready = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
  logic hreadyout, hresp, rst_out, wake_out, sleeping, stable, tflag;
  logic seen_rst = 1'b0, seen_wake = 1'b0;
  int miscompares = 0, checked = 0, cycles = 0;
  localparam logic [7:0] CTRL = watchdog_pkg::CONTROL_OFFSET;
  localparam logic [7:0] OPT = watchdog_pkg::OPTION_OFFSET;
  localparam logic [7:0] STAT = watchdog_pkg::STATUS_OFFSET;

  always #25 clk_in = ~clk_in;

  watchdog_timer watchdog_timer_inst (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata), .low_freq_internal_osc_in(osc),
    .config_watchdog_enable_in(cfg_en), .crystal_osc_mode_in(xtal), .osc_startup_timer_busy_in(busy),
    .clear_watchdog_instr_in(clr), .osc_fail_in(fail), .sleep_enter_in(slp), .wake_event_in(wake_ev),
    .lowfreq_sysclk_ready_in(ready), .watchdog_reset_out(rst_out), .watchdog_wake_out(wake_out),
    .sleeping_out(sleeping), .lowfreq_stable_flag_out(stable), .timeout_flag_out(tflag));

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (rst_out === 1'b1) seen_rst <= 1'b1;
    if (wake_out === 1'b1) seen_wake <= 1'b1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Single AHB-Lite transfer; waits on hready in both phases
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk_in);
    while (hreadyout !== 1'b1) @(posedge clk_in);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk_in);
    while (hreadyout !== 1'b1) @(posedge clk_in);
    rdata = hrdata;
  endtask

  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, exp, rdata);
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask

  task arm(input logic [7:0] opt, input logic [7:0] ctl);
    bus(1'b1, OPT, opt);
    bus(1'b1, CTRL, ctl);
  endtask

  // One oscillator period of eight system clocks, four high and four low
  task tick;
    @(posedge clk_in);
    osc <= 1'b1;
    repeat (4) @(posedge clk_in);
    osc <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task expect_out(input int n, input logic wake);
    int i;
    seen_rst = 1'b0;
    seen_wake = 1'b0;
    i = 0;
    while (i < n && !(seen_rst || seen_wake)) begin
      tick();
      i++;
    end
    chk("ticks to time-out", n, i);
    chk("wake pulse", {31'h0, wake}, {31'h0, seen_wake});
    chk("reset pulse", {31'h0, !wake}, {31'h0, seen_rst});
  endtask

  task no_out(input int n);
    seen_rst = 1'b0;
    seen_wake = 1'b0;
    repeat (n) tick();
    chk("no time-out", 32'h0, {31'h0, seen_rst | seen_wake});
  endtask

  task pulse_in(input int s);
    @(posedge clk_in);
    case (s)
      0: clr <= 1'b1;
      1: fail <= 1'b1;
      2: busy <= 1'b1;
      3: slp <= 1'b1;
      default: wake_ev <= 1'b1;
    endcase
    repeat ((s < 3) ? 3 : 1) @(posedge clk_in);
    {clr, fail, busy, slp, wake_ev} <= 5'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd("control reset", CTRL, 32'h08);
    rd("option reset", OPT, 32'hff);
    rd("status reset", STAT, 32'h00);
    bus(1'b1, CTRL, 8'hff);
    rd("control upper bits", CTRL, 32'h1f);
    rd("unmapped read", 8'h0c, 32'h00);
    bus(1'b1, CTRL, 8'h08);
  endtask

  task t_period;
    for (int c = 0; c < 3; c++) begin
      arm(8'h00, {3'h0, c[3:0], 1'b1});
      expect_out(32 << c, 1'b0);
      chk("time-out flag pin", 32'h1, {31'h0, tflag});
      rd("control after time-out", CTRL, 32'h08);
      rd("time-out flag", STAT, 32'h01);
      bus(1'b1, STAT, 8'h01);
    end
    rd("flag cleared", STAT, 32'h00);
    arm(8'h09, 8'h01);
    expect_out(64, 1'b0);
  endtask

  task t_enable;
    arm(8'h00, 8'h00);
    no_out(40);
    cfg_en <= 1'b1;
    expect_out(32, 1'b0);
    cfg_en <= 1'b0;
  endtask

  task t_clear;
    for (int s = 0; s < 3; s++) begin
      arm(8'h00, 8'h01);
      repeat (20) tick();
      pulse_in(s);
      expect_out(32, 1'b0);
    end
  endtask

  task t_sleep;
    arm(8'h00, 8'h01);
    repeat (20) tick();
    pulse_in(3);
    // Let the state register settle before looking at it
    @(negedge clk_in);
    chk("asleep", 32'h1, {31'h0, sleeping});
    expect_out(32, 1'b1);
    chk("awake after wake", 32'h0, {31'h0, sleeping});
    chk("stable flag low", 32'h0, {31'h0, stable});
    ready <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("stable flag high", 32'h1, {31'h0, stable});
    rd("wake flag", STAT, 32'h07);
    // Ticks counted in sleep must not survive an interrupt wake
    pulse_in(3);
    repeat (20) tick();
    pulse_in(4);
    expect_out(32, 1'b0);
  endtask

  task t_crystal;
    xtal <= 1'b1;
    arm(8'h00, 8'h01);
    pulse_in(3);
    pulse_in(4);
    rd("crystal hold", STAT, 32'h17);
    no_out(40);
    pulse_in(2);
    expect_out(32, 1'b0);
    xtal <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_period();
    t_enable();
    t_clear();
    t_sleep();
    t_crystal();
    end_sim();
  end
endmodule
